// File: bench/smw_mem_model.sv
`timescale 1ns/1ns
module smw_mem_model
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  mem_valid_i,
   input  wire smw_pkg::smw_mem_req_s mem_req_i,
   input  wire logic [3:0]            dly_i,
   output      logic                  mem_ack_o,
   output      logic [31:0]           mem_rdata_o,
   output      smw_pkg::smw_mem_req_s last_o,
   output      int unsigned           count_o
);
   import smw_pkg::*;
   logic [3:0] wait_reg;

   // Answer after dly_i cycles; read word is the inverted address so every word is distinct
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mem_ack_o   <= 1'b0;
         mem_rdata_o <= 32'h0;
         last_o      <= '0;
         count_o     <= 0;
         wait_reg    <= 4'h0;
      end
      else if (mem_valid_i && !mem_ack_o && wait_reg == dly_i)
      begin
         mem_ack_o   <= 1'b1;
         mem_rdata_o <= ~mem_req_i.addr;
         last_o      <= mem_req_i;
         count_o     <= count_o + 1;
         wait_reg    <= 4'h0;
      end
      else
      begin
         mem_ack_o   <= 1'b0;
         mem_rdata_o <= ~mem_rdata_o;  // Stale data inverts every cycle, matching the last read word on every second cycle
         wait_reg    <= (mem_valid_i && !mem_ack_o) ? wait_reg + 4'h1 : 4'h0;
      end
   end
endmodule // smw_mem_model

// File: bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import smw_pkg::*;
   logic                clk_i;
   logic                rst_i;
   logic                wb_cyc_i;
   logic                wb_stb_i;
   logic                wb_we_i;
   logic [WB_ADR_W-1:0] wb_adr_i;
   logic [3:0]          wb_sel_i;
   logic [WB_DAT_W-1:0] wb_dat_i;
   logic [WB_DAT_W-1:0] wb_dat_o;
   logic                wb_ack_o;
   logic                host_valid_i;
   smw_host_req_s       host_req_i;
   logic [7:0]          host_rdata_o;
   logic                host_ack_o;
   logic                host_mbox_event_o;
   logic                mem_valid_o;
   smw_mem_req_s        mem_req_o;
   logic                mem_ack_i;
   logic [31:0]         mem_rdata_i;
   logic [3:0]          mem_dly;
   smw_mem_req_s        mem_last;
   int unsigned         mem_count;
   int unsigned         cnt;
   int                  err_count;
   int                  checks;
   logic                ev_seen;
   logic [31:0]         rd;
   logic [7:0]          hb;
   logic [7:0]          hb0;

   smw_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .host_valid_i(host_valid_i),
      .host_req_i(host_req_i), .host_rdata_o(host_rdata_o), .host_ack_o(host_ack_o),
      .host_mbox_event_o(host_mbox_event_o), .mem_valid_o(mem_valid_o),
      .mem_req_o(mem_req_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));

   smw_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_valid_i(mem_valid_o),
      .mem_req_i(mem_req_o), .dly_i(mem_dly), .mem_ack_o(mem_ack_i),
      .mem_rdata_o(mem_rdata_i), .last_o(mem_last), .count_o(mem_count));

   // 50 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Classic single cycle; ack and event are sampled at the same edge
   task automatic wb_acc(input logic we, input logic [11:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'hF;
      wb_dat_i <= wd;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50)
         err_count++;
      rd = wb_dat_o;
      ev_seen = host_mbox_event_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   // Host request held until its ack is sampled
   task automatic host_acc(input logic we, input logic [2:0] a, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      host_valid_i <= 1'b1;
      host_req_i   <= '{we: we, addr: a, wdata: wd};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (host_ack_o !== 1'b1 && n < 100);
      if (n >= 100)
         err_count++;
      hb = host_rdata_o;
      host_valid_i <= 1'b0;
   endtask

   task automatic set_ofs(input logic [15:0] ofs);
      host_acc(1'b1, HADR_OFS_LO, ofs[7:0]);
      host_acc(1'b1, HADR_OFS_HI, ofs[15:8]);
   endtask

   task automatic complete_run();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog, far beyond the roughly 160 cycles the sequence needs
   initial
   begin
      #200000;
      err_count++;
      complete_run();
   end

   initial
   begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, host_valid_i} = 4'h0;
      {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      host_req_i = '0;
      mem_dly = 4'h0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int p = 0; p < 2; p++)
      begin
         wb_acc(1'b0, IDX_C2H_MBOX, 32'h0);
         chk("mbox reset", 32'h0, rd);
         wb_acc(1'b0, IDX_R0_BASE, 32'h0);
         chk("base reset", 32'h0, rd);
         wb_acc(1'b0, IDX_R0_RDLIM, 32'h0);
         chk("rdlim reset", 32'h0, rd);
         if (p == 0)
         begin
            wb_acc(1'b1, 12'h0FF, 32'hFFFFFFFF);
            wb_acc(1'b0, 12'h0FF, 32'h0);
            chk("unmapped", 32'h0, rd);
            wb_acc(1'b1, IDX_C2H_MBOX, 32'h000001A5);
            chk("mbox event", 32'h1, {31'h0, ev_seen});
            wb_acc(1'b1, IDX_R0_BASE, 32'h12345677);
            chk("no event", 32'h0, {31'h0, ev_seen});
            host_acc(1'b0, HADR_MBOX, 8'h00);
            chk("host mbox", 32'hA5, {24'h0, hb});
            host_acc(1'b1, HADR_MBOX, 8'h0F); // Host clears the low nibble
            wb_acc(1'b0, IDX_C2H_MBOX, 32'h0);
            chk("fw mbox", 32'hA0, rd);
            wb_acc(1'b0, IDX_R0_BASE, 32'h0);
            chk("base", 32'h12345674, rd);
            wb_acc(1'b1, IDX_R0_RDLIM, 32'hFFFFFFFF);
            wb_acc(1'b0, IDX_R0_RDLIM, 32'h0);
            chk("rdlim", 32'h00007FFC, rd);
            wb_acc(1'b1, IDX_R0_RDLIM, 32'h00000010);
            wb_acc(1'b1, IDX_R0_WRLIM, 32'h00000010);
            // Last word below the limit, prompt memory
            set_ofs(16'h000D);
            cnt = mem_count;
            host_acc(1'b0, 3'h6, 8'h00);
            chk("fetch count", 32'(cnt + 1), 32'(mem_count));
            chk("fetch addr", 32'h12345681, mem_last.addr);
            chk("fetch be", 32'hF, {28'h0, mem_last.be});
            chk("fetch byte", {24'h0, ~8'h34}, {24'h0, hb});
            hb0 = hb;
            // Word at the limit: no fetch, data register kept
            set_ofs(16'h0010);
            cnt = mem_count;
            host_acc(1'b0, 3'h6, 8'h00);
            chk("no fetch", 32'(cnt), 32'(mem_count));
            chk("kept byte", {24'h0, hb0}, {24'h0, hb});
            // Offset bit 15 set: region 1 read limit and base, slow memory
            mem_dly <= 4'h5;
            wb_acc(1'b1, IDX_R1_BASE, 32'h00200000);
            wb_acc(1'b1, IDX_R1_RDLIM, 32'h00007FFC);
            set_ofs(16'h8010);
            host_acc(1'b0, HADR_OFS_HI, 8'h00);
            chk("ofs high", 32'h80, {24'h0, hb});
            cnt = mem_count;
            host_acc(1'b0, 3'h4, 8'h00);
            chk("r1 fetch", 32'(cnt + 1), 32'(mem_count));
            chk("r1 base", 32'h0020, {16'h0, mem_last.addr[31:16]});
            // Write below and at the write limit
            set_ofs(16'h0008);
            cnt = mem_count;
            host_acc(1'b1, 3'h5, 8'h3C);
            chk("wr count", 32'(cnt + 1), 32'(mem_count));
            chk("wr addr", 32'h1234567C, mem_last.addr);
            chk("wr lane", 32'h123C, {19'h0, mem_last.we, mem_last.be, mem_last.wdata[15:8]});
            set_ofs(16'h0010);
            cnt = mem_count;
            host_acc(1'b1, 3'h4, 8'h55);
            chk("wr blocked", 32'(cnt), 32'(mem_count));
            // Second reset in mid-run
            @(posedge clk_i);
            rst_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
         end
      end
      complete_run();
   end
endmodule // tb_top

// File: design/smw_top.sv
// Function
// - Firmware owns an 8-bit mailbox register for passing a value to the host.
// - Every firmware write of that mailbox with byte lane 0 selected raises a notification event to the host.
// - Firmware view and host view of the mailbox are one storage element.
// - Region 0 base bits 31:2 give the region start; bits 1:0 are reserved.
// - A window access uses region 0 whenever offset bit 15 is zero.
// - A window access targets the region base plus the window offset.
// - A window data read with offset bit 15 zero compares offset 14:2 with the read limit.
// - Memory is fetched into the data register only when offset 14:2 is below the read limit.
// - A window write stores the addressed byte in memory only when offset 14:2 is below the write limit.
// - Offset bit 15 set selects region 1 instead of region 0.
`timescale 1ns/1ns
module smw_top
(
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         wb_cyc_i,
   input  wire logic                         wb_stb_i,
   input  wire logic                         wb_we_i,
   input  wire logic [smw_pkg::WB_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                   wb_sel_i,
   input  wire logic [smw_pkg::WB_DAT_W-1:0] wb_dat_i,
   output      logic [smw_pkg::WB_DAT_W-1:0] wb_dat_o,
   output      logic                         wb_ack_o,
   input  wire logic                         host_valid_i,
   input  wire smw_pkg::smw_host_req_s       host_req_i,
   output      logic [7:0]                   host_rdata_o,
   output      logic                         host_ack_o,
   output      logic                         host_mbox_event_o,
   output      logic                         mem_valid_o,
   output      smw_pkg::smw_mem_req_s        mem_req_o,
   input  wire logic                         mem_ack_i,
   input  wire logic [31:0]                  mem_rdata_i
);
   import smw_pkg::*;

   logic [7:0]   mbox_reg;
   logic [31:0]  r0_base_reg;
   logic [15:0]  r0_rdlim_reg;
   logic [15:0]  r0_wrlim_reg;
   logic [31:0]  r1_base_reg;
   logic [15:0]  r1_rdlim_reg;
   logic [15:0]  r1_wrlim_reg;
   logic [15:0]  ofs_reg;
   logic [31:0]  data_reg;
   logic         ack_reg;
   logic [31:0]  rdat_reg;
   logic         event_reg;
   smw_state_e   state_reg;
   smw_state_e   state_next;
   smw_host_req_s hreq_reg;
   logic         hack_reg;
   logic [7:0]   hrdata_reg;
   logic         mvalid_reg;
   smw_mem_req_s mreq_reg;

   // Bus decode
   wire          wb_acc;
   wire          wb_wr;
   wire [11:0]   wb_idx;
   wire          hit_mbox;
   wire          hit_r0b;
   wire          hit_r0r;
   wire          hit_r0w;
   wire          hit_r1b;
   wire          hit_r1r;
   wire          hit_r1w;
   wire          fw_mbox_wr;
   wire [31:0]   rd_mux;

   // Host decode
   wire          h_take;
   wire          h_is_data;
   wire [1:0]    h_lane;
   wire          h_mbox_clr;
   wire          h_ofs_wr;
   wire          win_region1;
   wire [31:0]   win_addr;
   wire          win_rd_ok;
   wire          win_wr_ok;
   wire          h_fetch;
   wire          h_store;
   wire [31:0]   data_merged;
   wire [7:0]    h_rd_byte;

   // Access strobe for reads and writes: decode goes through once per request, ack pulses for one cycle
   assign wb_acc = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wb_wr  = wb_acc & wb_we_i;
   assign wb_idx = wb_adr_i[WB_ADR_W-1:2];

   // Register hits; any other index answers zero and drops writes
   assign hit_mbox = (wb_idx == IDX_C2H_MBOX);
   assign hit_r0b  = (wb_idx == IDX_R0_BASE);
   assign hit_r0r  = (wb_idx == IDX_R0_RDLIM);
   assign hit_r0w  = (wb_idx == IDX_R0_WRLIM);
   assign hit_r1b  = (wb_idx == IDX_R1_BASE);
   assign hit_r1r  = (wb_idx == IDX_R1_RDLIM);
   assign hit_r1w  = (wb_idx == IDX_R1_WRLIM);
   assign fw_mbox_wr = wb_wr & hit_mbox & wb_sel_i[0];

   // Read mux; reserved bits read as zero
   assign rd_mux = hit_mbox ? {24'h000000, mbox_reg} :
                   hit_r0b  ? (r0_base_reg & BASE_MASK) :
                   hit_r0r  ? {16'h0000, r0_rdlim_reg & LIMIT_MASK} :
                   hit_r0w  ? {16'h0000, r0_wrlim_reg & LIMIT_MASK} :
                   hit_r1b  ? (r1_base_reg & BASE_MASK) :
                   hit_r1r  ? {16'h0000, r1_rdlim_reg & LIMIT_MASK} :
                   hit_r1w  ? {16'h0000, r1_wrlim_reg & LIMIT_MASK} :
                   32'h00000000;

   // Host request decode; a new one waits until the previous ack has gone
   assign h_take     = host_valid_i & (state_reg == ST_IDLE) & ~hack_reg;
   assign h_is_data  = host_req_i.addr[2] == HADR_DATA;
   assign h_lane     = host_req_i.addr[1:0];
   assign h_mbox_clr = h_take & host_req_i.we & (host_req_i.addr == HADR_MBOX);
   assign h_ofs_wr   = h_take & host_req_i.we & ~h_is_data &
                       ((host_req_i.addr == HADR_OFS_LO) | (host_req_i.addr == HADR_OFS_HI));
   assign h_fetch    = h_take & h_is_data & ~host_req_i.we & win_rd_ok;
   assign h_store    = h_take & h_is_data & host_req_i.we & win_wr_ok;

   // Window data with the host byte merged into its lane
   assign data_merged = (data_reg & ~({24'h000000, 8'hFF} << {h_lane, 3'b000})) |
                        ({24'h000000, host_req_i.wdata} << {h_lane, 3'b000});

   // Byte returned to the host for each register
   assign h_rd_byte = (hreq_reg.addr[2] == HADR_DATA) ?
                         data_reg[{hreq_reg.addr[1:0], 3'b000} +: 8] :
                      (hreq_reg.addr == HADR_OFS_LO) ? ofs_reg[7:0] :
                      (hreq_reg.addr == HADR_OFS_HI) ? ofs_reg[15:8] :
                      (hreq_reg.addr == HADR_MBOX)   ? mbox_reg :
                      8'h00;

   // Region select, target address and limit checks
   smw_window_map u_map
   (
      .ofs_i      (ofs_reg),
      .r0_base_i  (r0_base_reg),
      .r0_rdlim_i (r0_rdlim_reg),
      .r0_wrlim_i (r0_wrlim_reg),
      .r1_base_i  (r1_base_reg),
      .r1_rdlim_i (r1_rdlim_reg),
      .r1_wrlim_i (r1_wrlim_reg),
      .region1_o  (win_region1),
      .addr_o     (win_addr),
      .rd_ok_o    (win_rd_ok),
      .wr_ok_o    (win_wr_ok)
   );

   // Wishbone answer, one cycle after the strobe
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h00000000;
      end
      else
      begin
         ack_reg  <= wb_acc;
         rdat_reg <= wb_acc ? rd_mux : 32'h00000000;
      end
   end

   // Mailbox: one cell for both views; a firmware write wins over a host clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mbox_reg  <= MBOX_RST;
         event_reg <= 1'b0;
      end
      else
      begin
         if (fw_mbox_wr)
            mbox_reg <= wb_dat_i[7:0];
         else if (h_mbox_clr)
            mbox_reg <= mbox_reg & ~host_req_i.wdata;
         event_reg <= fw_mbox_wr;
      end
   end

   // Region registers with byte lane writes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r0_base_reg  <= BASE_RST;
         r0_rdlim_reg <= LIMIT_RST;
         r0_wrlim_reg <= LIMIT_RST;
         r1_base_reg  <= BASE_RST;
         r1_rdlim_reg <= LIMIT_RST;
         r1_wrlim_reg <= LIMIT_RST;
      end
      else if (wb_wr)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (wb_sel_i[b] && hit_r0b)
               r0_base_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            if (wb_sel_i[b] && hit_r1b)
               r1_base_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
         end
         for (int b = 0; b < 2; b++)
         begin
            if (wb_sel_i[b] && hit_r0r)
               r0_rdlim_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            if (wb_sel_i[b] && hit_r0w)
               r0_wrlim_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            if (wb_sel_i[b] && hit_r1r)
               r1_rdlim_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            if (wb_sel_i[b] && hit_r1w)
               r1_wrlim_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
         end
      end
   end

   // Host sequencer: data accesses inside a limit go through memory
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: if (h_take) state_next = (h_fetch | h_store) ? ST_MEM : ST_DONE;
         ST_MEM:  if (mem_ack_i) state_next = ST_DONE;
         ST_DONE: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   // Offset and window data registers, memory request, host answer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg  <= ST_IDLE;
         hreq_reg   <= '0;
         ofs_reg    <= OFS_RST;
         data_reg   <= DATA_RST;
         mvalid_reg <= 1'b0;
         mreq_reg   <= '0;
         hack_reg   <= 1'b0;
         hrdata_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         hack_reg  <= (state_reg == ST_DONE);
         if (h_take)
            hreq_reg <= host_req_i;
         if (h_ofs_wr && host_req_i.addr == HADR_OFS_LO)
            ofs_reg[7:0] <= host_req_i.wdata;
         if (h_ofs_wr && host_req_i.addr == HADR_OFS_HI)
            ofs_reg[15:8] <= host_req_i.wdata;
         // A write always lands in the data register, memory only inside the limit
         if (h_take && h_is_data && host_req_i.we)
            data_reg <= data_merged;
         if (h_fetch || h_store)
         begin
            mvalid_reg     <= 1'b1;
            mreq_reg.we    <= host_req_i.we;
            mreq_reg.addr  <= win_addr;
            mreq_reg.wdata <= data_merged;
            mreq_reg.be    <= host_req_i.we ? lane_onehot(h_lane) : 4'hF;
         end
         else if (mem_ack_i)
            mvalid_reg <= 1'b0;
         if (state_reg == ST_MEM && mem_ack_i && !mreq_reg.we)
            data_reg <= mem_rdata_i;
         if (state_reg == ST_DONE)
            hrdata_reg <= h_rd_byte;
      end
   end

   assign wb_dat_o          = rdat_reg;
   assign wb_ack_o          = ack_reg;
   assign host_rdata_o      = hrdata_reg;
   assign host_ack_o        = hack_reg;
   assign host_mbox_event_o = event_reg;
   assign mem_valid_o       = mvalid_reg;
   assign mem_req_o         = mreq_reg;

   // Checks
   mbox_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fw_mbox_wr |=> host_mbox_event_o && mbox_reg == $past(wb_dat_i[7:0]))
      else $error("mailbox write gave no event or value");
   mbox_alias_a: assert property (@(posedge clk_i) disable iff (rst_i)
      h_mbox_clr && !fw_mbox_wr |=> mbox_reg == ($past(mbox_reg) & ~$past(host_req_i.wdata)))
      else $error("host clear not seen in shared mailbox");
   mbox_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_acc && !wb_we_i && hit_mbox && !h_mbox_clr |=> wb_ack_o && wb_dat_o[7:0] == mbox_reg)
      else $error("mailbox read mismatch");
   base_resv_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_acc && !wb_we_i && hit_r0b |=> wb_dat_o[1:0] == 2'b00 && wb_dat_o[31:2] == r0_base_reg[31:2])
      else $error("base read wrong");
   region_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !ofs_reg[OFS_REGION_BIT] |-> win_addr == (r0_base_reg & BASE_MASK) + {16'h0000, ofs_reg})
      else $error("region 0 not used");
   region_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ofs_reg[OFS_REGION_BIT] |-> win_region1 &&
         win_addr == (r1_base_reg & BASE_MASK) + {16'h0000, ofs_reg})
      else $error("region 1 not used");
   fetch_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      h_take && h_is_data && !host_req_i.we && !ofs_reg[15] && ofs_reg[14:2] >= r0_rdlim_reg[14:2]
      |=> !mem_valid_o ##1 host_ack_o)
      else $error("fetch beyond read limit");
   fetch_ok_a: assert property (@(posedge clk_i) disable iff (rst_i)
      h_take && h_is_data && !host_req_i.we && !ofs_reg[15] && ofs_reg[14:2] < r0_rdlim_reg[14:2]
      |=> mem_valid_o && !mem_req_o.we && mem_req_o.addr == $past(win_addr))
      else $error("read inside limit not fetched");
   write_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      h_take && h_is_data && host_req_i.we && !win_wr_ok |=> !mem_valid_o)
      else $error("write beyond write limit");
   reset_clear_a: assert property (@(posedge clk_i)
      rst_i |=> mbox_reg == MBOX_RST && r0_base_reg == BASE_RST && r0_rdlim_reg == LIMIT_RST)
      else $error("reset did not clear registers");

endmodule // smw_top

// File: design/smw_window_map.sv
`timescale 1ns/1ns
module smw_window_map
(
   input  wire logic [15:0] ofs_i,
   input  wire logic [31:0] r0_base_i,
   input  wire logic [15:0] r0_rdlim_i,
   input  wire logic [15:0] r0_wrlim_i,
   input  wire logic [31:0] r1_base_i,
   input  wire logic [15:0] r1_rdlim_i,
   input  wire logic [15:0] r1_wrlim_i,
   output      logic        region1_o,
   output      logic [31:0] addr_o,
   output      logic        rd_ok_o,
   output      logic        wr_ok_o
);
   import smw_pkg::*;

   wire [31:0] sel_base;
   wire [15:0] sel_rdlim;
   wire [15:0] sel_wrlim;

   // Offset bit 15 picks the region; zero means region 0
   assign region1_o = ofs_i[OFS_REGION_BIT];
   assign sel_base  = region1_o ? r1_base_i  : r0_base_i;
   assign sel_rdlim = region1_o ? r1_rdlim_i : r0_rdlim_i;
   assign sel_wrlim = region1_o ? r1_wrlim_i : r0_wrlim_i;

   // Target is base plus offset; reserved base bits 1:0 never add in, carry past 31 wraps
   assign addr_o  = (sel_base & BASE_MASK) + {16'h0000, ofs_i};
   assign rd_ok_o = below_limit(ofs_i, sel_rdlim);
   assign wr_ok_o = below_limit(ofs_i, sel_wrlim);

endmodule // smw_window_map

// File: shared/smw_pkg.sv
package smw_pkg;

   // Register indices on the controller bus; byte address is four times the index
   localparam logic [11:0] IDX_C2H_MBOX = 12'h001;
   localparam logic [11:0] IDX_R0_BASE  = 12'h104;
   localparam logic [11:0] IDX_R0_RDLIM = 12'h108;
   localparam logic [11:0] IDX_R0_WRLIM = 12'h10A;
   localparam logic [11:0] IDX_R1_BASE  = 12'h10C;
   localparam logic [11:0] IDX_R1_RDLIM = 12'h110;
   localparam logic [11:0] IDX_R1_WRLIM = 12'h112;

   // Bus widths
   localparam int unsigned WB_ADR_W = 14;
   localparam int unsigned WB_DAT_W = 32;

   // Reset values
   localparam logic [7:0]  MBOX_RST  = 8'h00;
   localparam logic [31:0] BASE_RST  = 32'h00000000;
   localparam logic [15:0] LIMIT_RST = 16'h0000;
   localparam logic [15:0] OFS_RST   = 16'h0000;
   localparam logic [31:0] DATA_RST  = 32'h00000000;

   // Field layouts
   localparam int unsigned  OFS_REGION_BIT = 15;
   localparam logic [31:0]  BASE_MASK      = 32'hFFFFFFFC;
   localparam logic [15:0]  LIMIT_MASK     = 16'h7FFC;

   // Host side register addresses of the shared memory port
   localparam logic [2:0] HADR_OFS_LO = 3'h0;
   localparam logic [2:0] HADR_OFS_HI = 3'h1;
   localparam logic [2:0] HADR_MBOX   = 3'h2;
   localparam logic       HADR_DATA   = 1'b1;  // Address bit 2 set: window data bytes

   // Host access sequencer, Gray coded along idle, memory, done
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_MEM  = 2'b01,
      ST_DONE = 2'b11
   } smw_state_e;

   // One host access to the port
   typedef struct packed
   {
      logic       we;
      logic [2:0] addr;
      logic [7:0] wdata;
   } smw_host_req_s;

   // One access to internal memory
   typedef struct packed
   {
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0]  be;
   } smw_mem_req_s;

   // Window offset bits 14:2 compared with a limit field bits 14:2
   function automatic logic below_limit(input logic [15:0] ofs, input logic [15:0] lim);
      below_limit = (ofs[14:2] < lim[14:2]);
   endfunction

   // Byte lane from a host data address
   function automatic logic [3:0] lane_onehot(input logic [1:0] lane);
      lane_onehot = 4'h1 << lane;
   endfunction

endpackage
